// file: verilog/apss_pkg.sv
package apss_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ          = 200;
    localparam int unsigned T_ABORT_US       = 3;
    localparam int unsigned T_RST_ABORT_US   = 6;
    localparam int unsigned T_FAST_SLEEP_US  = 15;
    localparam int unsigned T_FAST_STBY_US   = 85;
    localparam int unsigned T_SLEEP_MS       = 20;
    localparam int unsigned T_STBY_MS        = 20;
    localparam int unsigned T_SWRST_MS       = 28;
    localparam int unsigned T_POR_MS         = 10;
    localparam int unsigned T_HWRST_MS       = 10;
    localparam int unsigned ABORT_CYC        = T_ABORT_US * CLK_MHZ;
    localparam int unsigned RST_ABORT_CYC    = T_RST_ABORT_US * CLK_MHZ;
    localparam int unsigned FAST_SLEEP_CYC   = T_FAST_SLEEP_US * CLK_MHZ;
    localparam int unsigned FAST_STBY_CYC    = T_FAST_STBY_US * CLK_MHZ;
    localparam int unsigned SLEEP_CYC        = T_SLEEP_MS * 1000 * CLK_MHZ;
    localparam int unsigned STBY_CYC         = T_STBY_MS * 1000 * CLK_MHZ;
    localparam int unsigned SWRST_CYC        = T_SWRST_MS * 1000 * CLK_MHZ;
    localparam int unsigned POR_CYC          = T_POR_MS * 1000 * CLK_MHZ;
    localparam int unsigned HWRST_CYC        = T_HWRST_MS * 1000 * CLK_MHZ;
    localparam int unsigned SLEEP_PUP_CYC    = 1000;
    localparam int unsigned STBY_PUP_CYC     = 200;

    // ------------------------------------------------------------
    // register map (byte offsets)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL          = 8'h00;
    localparam logic [7:0] OFS_CMD           = 8'h04;
    localparam logic [7:0] OFS_STAT          = 8'h08;

    // control_reg_one fields
    localparam int unsigned CTRL_PD_LSB      = 0;
    localparam int unsigned CTRL_CAL_LSB     = 2;
    localparam logic [1:0]  CTRL_PD_RST      = 2'h0;
    localparam logic [1:0]  CTRL_CAL_RST     = 2'h0;
    // command register field
    localparam int unsigned CMD_KIND_LSB     = 0;
    // status fields
    localparam int unsigned STAT_PST_LSB     = 0;
    localparam int unsigned STAT_INRST_BIT   = 2;
    localparam int unsigned STAT_BUSY_BIT    = 3;
    localparam int unsigned STAT_CAL_BIT     = 4;

    // power_down_select encodings
    localparam logic [1:0] PD_SLEEP          = 2'h1;
    localparam logic [1:0] PD_STBY           = 2'h2;
    localparam logic [1:0] PD_RESET          = 2'h3;
    // command kinds
    localparam logic [1:0] KIND_PD           = 2'h1;
    localparam logic [1:0] KIND_CAL          = 2'h2;
    localparam logic [1:0] KIND_CONV         = 2'h3;
    // power_state_status encodings
    localparam logic [1:0] PST_CONV          = 2'h0;
    localparam logic [1:0] PST_SLEEP         = 2'h1;
    localparam logic [1:0] PST_STBY          = 2'h2;
    localparam logic [1:0] PST_RESET         = 2'h3;

    typedef enum logic [3:0] {
        APSS_RESET     = 4'h0,
        APSS_STBY      = 4'h1,
        APSS_SLEEP     = 4'h2,
        APSS_TO_SLEEP  = 4'h3,
        APSS_TO_STBY   = 4'h4,
        APSS_PWRUP     = 4'h5,
        APSS_CONV      = 4'h6,
        APSS_CAL       = 4'h7,
        APSS_SWRST     = 4'h8
    } apss_state_e;

endpackage : apss_pkg

// file: verilog/apss_sync.sv
`timescale 1ns/100ps
module apss_sync #(
    parameter int unsigned WIDTH = 2
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // resets to all ones: the pins it carries are active-low resets
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            meta_reg <= '1;
            sync_out <= '1;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule : apss_sync

// file: verilog/apss_timer.sv
`timescale 1ns/100ps
module apss_timer #(
    parameter int unsigned WIDTH = 32
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_val,
    output logic                  done
);

    logic [WIDTH-1:0] cnt_reg;

    // done pulses load_val cycles after the load edge
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cnt_reg <= '0;
            done    <= 1'b0;
        end else if (load) begin
            cnt_reg <= load_val;
            done    <= 1'b0;
        end else begin
            done <= (cnt_reg == WIDTH'(1));
            if (cnt_reg != '0) begin
                cnt_reg <= cnt_reg - WIDTH'(1);
            end
        end
    end

endmodule : apss_timer

// file: verilog/apss_seq.sv
`timescale 1ns/100ps
module apss_seq #(
    parameter int unsigned SLEEP_PUP_CYC = apss_pkg::SLEEP_PUP_CYC,
    parameter int unsigned STBY_PUP_CYC  = apss_pkg::STBY_PUP_CYC,
    parameter int unsigned SLEEP_CYC     = apss_pkg::SLEEP_CYC,
    parameter int unsigned STBY_CYC      = apss_pkg::STBY_CYC,
    parameter int unsigned SWRST_CYC     = apss_pkg::SWRST_CYC,
    parameter int unsigned POR_CYC       = apss_pkg::POR_CYC,
    parameter int unsigned HWRST_CYC     = apss_pkg::HWRST_CYC,
    parameter int unsigned FAST_STBY_CYC = apss_pkg::FAST_STBY_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        hw_reset_n,
    input  wire logic        por_n,
    input  wire logic        cal_done,
    output logic             conv_run,
    output logic             cal_run,
    output logic             analog_on,
    output logic             regs_default
);

    // ------------------------------------------------------------
    // delay loads
    // ------------------------------------------------------------
    // the timer load is registered and done is registered, so two
    // cycles of the budget are spent in the handshake
    function automatic logic [31:0] apss_dly(input int unsigned cyc);
        apss_dly = (cyc > 2) ? 32'(cyc - 2) : 32'h1;
    endfunction : apss_dly

    localparam logic [31:0] LD_SLEEP     = apss_dly(SLEEP_CYC);
    localparam logic [31:0] LD_STBY      = apss_dly(STBY_CYC);
    localparam logic [31:0] LD_SWRST     = apss_dly(SWRST_CYC);
    localparam logic [31:0] LD_POR       = apss_dly(POR_CYC);
    localparam logic [31:0] LD_HWRST     = apss_dly(HWRST_CYC);
    localparam logic [31:0] LD_ABORT     = apss_dly(apss_pkg::ABORT_CYC);
    localparam logic [31:0] LD_RST_ABORT = apss_dly(apss_pkg::RST_ABORT_CYC);
    localparam logic [31:0] LD_PUP_SLEEP = apss_dly(SLEEP_PUP_CYC + apss_pkg::ABORT_CYC);
    localparam logic [31:0] LD_PUP_STBY  = apss_dly(STBY_PUP_CYC + apss_pkg::ABORT_CYC);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] pins_sync;
    logic       hw_rst_s_n;
    logic       por_s_n;

    apss_sync #(
        .WIDTH    (2)
    ) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_in ({hw_reset_n, por_n}),
        .sync_out (pins_sync)
    );

    assign hw_rst_s_n = pins_sync[1];
    assign por_s_n    = pins_sync[0];

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    apss_pkg::apss_state_e state_reg;
    apss_pkg::apss_state_e target_reg;
    logic [1:0]            pstat_reg;
    logic                  in_reset_reg;
    logic                  tmr_load_reg;
    logic [31:0]           tmr_val_reg;
    logic                  tmr_done;
    logic [1:0]            pd_sel_reg;
    logic [1:0]            cal_sel_reg;
    logic                  hw_seen_reg;
    logic                  por_seen_reg;

    apss_timer #(
        .WIDTH    (32)
    ) u_timer (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .load     (tmr_load_reg),
        .load_val (tmr_val_reg),
        .done     (tmr_done)
    );

    // ------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------
    logic       bus_req;
    logic       wr_ctrl;
    logic       wr_cmd;
    logic [1:0] cmd_kind;
    logic       stable;
    logic       cmd_conv;
    logic       cmd_pd;
    logic       cmd_cal;

    // every field of this block sits in byte lane 0, so a write needs that lane
    function automatic logic apss_wr_hit(input logic       we,
                                         input logic [3:0] sel,
                                         input logic [7:0] adr,
                                         input logic [7:0] ofs);
        apss_wr_hit = we & sel[0] & (adr == ofs);
    endfunction : apss_wr_hit

    // answers every access one cycle after it is taken
    assign bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_ctrl  = bus_req & apss_wr_hit(wb_we_i, wb_sel_i, wb_adr_i, apss_pkg::OFS_CTRL);
    assign wr_cmd   = bus_req & apss_wr_hit(wb_we_i, wb_sel_i, wb_adr_i, apss_pkg::OFS_CMD);
    assign cmd_kind = wb_dat_i[apss_pkg::CMD_KIND_LSB +: 2];
    // one decode per command kind, shared by every state that takes it
    assign cmd_conv = wr_cmd & (cmd_kind == apss_pkg::KIND_CONV);
    assign cmd_pd   = wr_cmd & (cmd_kind == apss_pkg::KIND_PD);
    assign cmd_cal  = wr_cmd & (cmd_kind == apss_pkg::KIND_CAL);
    // a command is accepted only in a settled state; nothing is queued
    assign stable   = (state_reg == apss_pkg::APSS_STBY) | (state_reg == apss_pkg::APSS_SLEEP) |
                      (state_reg == apss_pkg::APSS_CONV) | (state_reg == apss_pkg::APSS_CAL);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wb_dat_o <= 32'h0;
        end else if (bus_req & ~wb_we_i) begin
            case (wb_adr_i)
                apss_pkg::OFS_CTRL: begin
                    wb_dat_o <= {28'h0, cal_sel_reg, pd_sel_reg};
                end
                apss_pkg::OFS_STAT: begin
                    wb_dat_o <= {27'h0, cal_run, ~stable, in_reset_reg, pstat_reg};
                end
                default: begin
                    wb_dat_o <= 32'h0;
                end
            endcase
        end
    end

    // control register; locked while a reset sequence runs
    always_ff @(posedge core_clk) begin
        if (!rst_n || regs_default) begin
            pd_sel_reg  <= apss_pkg::CTRL_PD_RST;
            cal_sel_reg <= apss_pkg::CTRL_CAL_RST;
        end else if (wr_ctrl && !in_reset_reg) begin
            pd_sel_reg  <= wb_dat_i[apss_pkg::CTRL_PD_LSB +: 2];
            cal_sel_reg <= wb_dat_i[apss_pkg::CTRL_CAL_LSB +: 2];
        end
    end

    // ------------------------------------------------------------
    // reset pin edge tracking
    // ------------------------------------------------------------
    // a held pin pulses regs_default once, not on every cycle; the sequence restarts every cycle
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            hw_seen_reg  <= 1'b0;
            por_seen_reg <= 1'b0;
        end else begin
            hw_seen_reg  <= ~hw_rst_s_n;
            por_seen_reg <= ~por_s_n;
        end
    end

    // ------------------------------------------------------------
    // power state machine
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_reg    <= apss_pkg::APSS_RESET;
            target_reg   <= apss_pkg::APSS_STBY;
            pstat_reg    <= apss_pkg::PST_RESET;
            in_reset_reg <= 1'b1;
            tmr_load_reg <= 1'b1;
            tmr_val_reg  <= LD_POR;
            regs_default <= 1'b1;
        end else begin
            tmr_load_reg <= 1'b0;
            regs_default <= 1'b0;
            if (!por_s_n) begin
                // held in reset while supplies are low; count starts on release
                state_reg    <= apss_pkg::APSS_RESET;
                pstat_reg    <= apss_pkg::PST_RESET;
                in_reset_reg <= 1'b1;
                tmr_load_reg <= 1'b1;
                tmr_val_reg  <= LD_POR;
                regs_default <= ~por_seen_reg;
            end else if (!hw_rst_s_n) begin
                state_reg    <= apss_pkg::APSS_RESET;
                pstat_reg    <= apss_pkg::PST_RESET;
                in_reset_reg <= 1'b1;
                tmr_load_reg <= 1'b1;
                tmr_val_reg  <= LD_HWRST;
                regs_default <= ~hw_seen_reg;
            end else begin
                case (state_reg)
                    apss_pkg::APSS_RESET, apss_pkg::APSS_SWRST: begin
                        // commands of every kind are ignored here
                        if (tmr_done) begin
                            state_reg    <= apss_pkg::APSS_STBY;
                            pstat_reg    <= apss_pkg::PST_STBY;
                            in_reset_reg <= 1'b0;
                        end
                    end
                    apss_pkg::APSS_STBY, apss_pkg::APSS_SLEEP: begin
                        if (cmd_conv) begin
                            state_reg    <= apss_pkg::APSS_PWRUP;
                            target_reg   <= apss_pkg::APSS_CONV;
                            tmr_load_reg <= 1'b1;
                            tmr_val_reg  <= (state_reg == apss_pkg::APSS_SLEEP) ?
                                            LD_PUP_SLEEP : LD_PUP_STBY;
                        end else if (cmd_pd) begin
                            if (pd_sel_reg == apss_pkg::PD_SLEEP &&
                                state_reg == apss_pkg::APSS_STBY) begin
                                state_reg    <= apss_pkg::APSS_TO_SLEEP;
                                tmr_load_reg <= 1'b1;
                                tmr_val_reg  <= LD_SLEEP;
                            end else if (pd_sel_reg == apss_pkg::PD_STBY &&
                                         state_reg == apss_pkg::APSS_SLEEP) begin
                                state_reg    <= apss_pkg::APSS_TO_STBY;
                                tmr_load_reg <= 1'b1;
                                tmr_val_reg  <= LD_STBY;
                            end else if (pd_sel_reg == apss_pkg::PD_RESET &&
                                         state_reg == apss_pkg::APSS_STBY) begin
                                state_reg    <= apss_pkg::APSS_SWRST;
                                pstat_reg    <= apss_pkg::PST_RESET;
                                in_reset_reg <= 1'b1;
                                regs_default <= 1'b1;
                                tmr_load_reg <= 1'b1;
                                tmr_val_reg  <= LD_SWRST;
                            end
                        end else if (cmd_cal &&
                                     state_reg == apss_pkg::APSS_STBY) begin
                            state_reg <= apss_pkg::APSS_CAL;
                        end
                    end
                    apss_pkg::APSS_CONV, apss_pkg::APSS_CAL: begin
                        if (cmd_pd &&
                            pd_sel_reg == apss_pkg::PD_RESET) begin
                            state_reg    <= apss_pkg::APSS_SWRST;
                            pstat_reg    <= apss_pkg::PST_RESET;
                            in_reset_reg <= 1'b1;
                            regs_default <= 1'b1;
                            tmr_load_reg <= 1'b1;
                            tmr_val_reg  <= LD_RST_ABORT;
                        end else if (cmd_pd &&
                                     pd_sel_reg == apss_pkg::PD_SLEEP) begin
                            state_reg    <= apss_pkg::APSS_TO_SLEEP;
                            tmr_load_reg <= 1'b1;
                            tmr_val_reg  <= LD_ABORT;
                        end else if (cmd_pd &&
                                     pd_sel_reg == apss_pkg::PD_STBY) begin
                            state_reg    <= apss_pkg::APSS_TO_STBY;
                            tmr_load_reg <= 1'b1;
                            tmr_val_reg  <= LD_ABORT;
                        end else if (wr_ctrl && state_reg == apss_pkg::APSS_CONV) begin
                            state_reg    <= apss_pkg::APSS_TO_STBY;
                            tmr_load_reg <= 1'b1;
                            tmr_val_reg  <= LD_ABORT;
                        end else if (state_reg == apss_pkg::APSS_CAL && cal_done) begin
                            state_reg <= apss_pkg::APSS_STBY;
                            pstat_reg <= apss_pkg::PST_STBY;
                        end
                    end
                    apss_pkg::APSS_TO_SLEEP: begin
                        if (tmr_done) begin
                            state_reg <= apss_pkg::APSS_SLEEP;
                            pstat_reg <= apss_pkg::PST_SLEEP;
                        end
                    end
                    apss_pkg::APSS_TO_STBY: begin
                        if (tmr_done) begin
                            state_reg <= apss_pkg::APSS_STBY;
                            pstat_reg <= apss_pkg::PST_STBY;
                        end
                    end
                    apss_pkg::APSS_PWRUP: begin
                        if (tmr_done) begin
                            state_reg <= target_reg;
                            pstat_reg <= apss_pkg::PST_CONV;
                        end
                    end
                    default: begin
                        state_reg <= apss_pkg::APSS_RESET;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // power and activity outputs
    // ------------------------------------------------------------
    // analog stays on through the sleep entry so it powers down last
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            conv_run  <= 1'b0;
            cal_run   <= 1'b0;
            analog_on <= 1'b0;
        end else begin
            conv_run  <= (state_reg == apss_pkg::APSS_CONV);
            cal_run   <= (state_reg == apss_pkg::APSS_CAL);
            analog_on <= (state_reg != apss_pkg::APSS_SLEEP) &&
                         (state_reg != apss_pkg::APSS_RESET);
        end
    end

endmodule : apss_seq

// file: test/apss_seq_properties.sv
`timescale 1ns/100ps
module apss_seq_properties (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        hw_reset_n,
    input wire logic        por_n,
    input wire logic        conv_run,
    input wire logic        cal_run,
    input wire logic        analog_on,
    input wire logic        regs_default
);
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence stat_rd;
        wb_ack_o && !wb_we_i && wb_adr_i == apss_pkg::OFS_STAT;
    endsequence
    sequence req_open;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    chk_ack_answer: assert property (req_open |=> wb_ack_o)
        else $error("request not answered");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_reset_flag: assert property (stat_rd ##0 wb_dat_o[2] |-> wb_dat_o[1:0] == 2'h3)
        else $error("reset flag without reset status");
    chk_stat_width: assert property (stat_rd |-> wb_dat_o[31:5] == 27'h0)
        else $error("status upper bits set");
    chk_sleep_flags: assert property (stat_rd ##0 wb_dat_o[1:0] == 2'h1 |-> !wb_dat_o[2])
        else $error("sleep status with reset flag");
    chk_run_excl: assert property (!(conv_run && cal_run))
        else $error("conversion and calibration together");
    chk_hwrst_stop: assert property (!hw_reset_n [*6] |-> !conv_run && !cal_run && !analog_on)
        else $error("activity during pin reset");
    chk_por_stop: assert property (!por_n [*6] |-> !conv_run && !cal_run && !analog_on)
        else $error("activity during power-on reset");
    chk_dflt_pulse: assert property (regs_default |=> !regs_default)
        else $error("defaults pulse longer than one cycle");
endmodule : apss_seq_properties

bind apss_seq apss_seq_properties u_chk (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .hw_reset_n(hw_reset_n), .por_n(por_n), .conv_run(conv_run),
    .cal_run(cal_run), .analog_on(analog_on), .regs_default(regs_default));

// file: test/apss_cal_model.sv
`timescale 1ns/100ps
module apss_cal_model #(
    parameter int unsigned DONE_CYC = 3000
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic cal_run,
    output logic      cal_done
);
    // slow engine: every abort in the bench lands before it would finish
    int unsigned cnt_reg;
    always_ff @(posedge core_clk) begin
        cnt_reg  <= (rst_n && cal_run) ? cnt_reg + 1 : 0;
        cal_done <= rst_n && cal_run && cnt_reg == DONE_CYC;
    end
endmodule : apss_cal_model

// file: test/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    localparam int SLP = 40, SBY = 40, SWR = 56, PRC = 50, HWR = 50, SPU = 100, BPU = 20;
    localparam int AB = apss_pkg::ABORT_CYC, RAB = apss_pkg::RST_ABORT_CYC;
    logic core_clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, hw_n = 1, por = 1, cal_done;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0, wb_dat_o, q;
    logic        wb_ack_o, conv_run, cal_run, analog_on, regs_default;
    int fail_count = 0, num_checks = 0, cnt = 0, dflt_n = 0, d0 = 0;
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) cnt <= cnt + 1;
    always @(posedge core_clk) dflt_n <= dflt_n + (regs_default === 1'b1);
    apss_seq #(.SLEEP_PUP_CYC(SPU), .STBY_PUP_CYC(BPU), .SLEEP_CYC(SLP), .STBY_CYC(SBY),
        .SWRST_CYC(SWR), .POR_CYC(PRC), .HWRST_CYC(HWR)) DUT (.core_clk(core_clk), .rst_n(rst_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .hw_reset_n(hw_n), .por_n(por),
        .cal_done(cal_done), .conv_run(conv_run), .cal_run(cal_run), .analog_on(analog_on),
        .regs_default(regs_default));
    apss_cal_model u_cal (.core_clk(core_clk), .rst_n(rst_n), .cal_run(cal_run),
        .cal_done(cal_done));
    task results;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
        do begin @(posedge core_clk); n++; end while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o;
        cyc <= 0; stb <= 0; we <= 0;
        if (n >= 50) begin chk("ack", 1, 0); results(); end
    endtask : wb
    task cmd(input logic [1:0] pd, input logic [1:0] k); // pd 0 leaves control alone
        if (pd != 2'h0) wb(1, apss_pkg::OFS_CTRL, {30'h0, pd});
        wb(1, apss_pkg::OFS_CMD, {30'h0, k});
    endtask : cmd
    task st(input string nm, input logic [4:0] e, input int n);
        repeat (n) @(posedge core_clk);
        wb(0, apss_pkg::OFS_STAT, 0);
        chk(nm, e, q[4:0]);
    endtask : st
    // polls until the state shows; too early means status moved before the change ended
    task pst(input string nm, input logic [1:0] e, input int hi);
        int t0;
        t0 = cnt;
        do wb(0, apss_pkg::OFS_STAT, 0); while (q[1:0] !== e && cnt - t0 < hi + 30);
        chk(nm, e, q[1:0]);
        chk({nm, "_early"}, 1, cnt - t0 >= hi - 10);
        if (q[1:0] !== e) results();
        $display("test %s done", nm);
    endtask : pst
    initial begin
        repeat (6) @(posedge core_clk);
        rst_n <= 1;
        st("por_flags", 5'h0f, 0);
        cmd(0, apss_pkg::KIND_CONV); st("conv_in_reset", 5'h0f, 0);
        cmd(0, apss_pkg::KIND_PD); st("sleep_in_reset", 5'h0f, 0);
        pst("por", apss_pkg::PST_STBY, PRC - 20); st("stby_flags", 5'h02, 0);
        wb(1, 8'h0c, 32'hffff_ffff); wb(0, 8'h0c, 0); chk("unmapped", 0, q);
        cmd(apss_pkg::PD_SLEEP, apss_pkg::KIND_PD); pst("sleep", apss_pkg::PST_SLEEP, SLP);
        chk("analog_on", 0, analog_on);
        cmd(0, apss_pkg::KIND_PD); st("sleep_again", 5'h01, 60);
        cmd(apss_pkg::PD_RESET, apss_pkg::KIND_PD); st("swrst_sleep", 5'h01, 60);
        cmd(apss_pkg::PD_STBY, apss_pkg::KIND_PD); pst("stby", apss_pkg::PST_STBY, SBY);
        cmd(0, apss_pkg::KIND_PD); st("stby_again", 5'h02, 60);
        cmd(0, apss_pkg::KIND_CONV); pst("conv_stby", apss_pkg::PST_CONV, BPU + AB);
        chk("conv_run", 1, conv_run);
        chk("analog_conv", 1, analog_on);
        cmd(apss_pkg::PD_STBY, 2'h0); pst("ctl_abort", apss_pkg::PST_STBY, AB);
        cmd(apss_pkg::PD_SLEEP, apss_pkg::KIND_CONV); pst("f1", apss_pkg::PST_CONV, BPU + AB);
        cmd(0, apss_pkg::KIND_PD); pst("fast_sleep", apss_pkg::PST_SLEEP, AB);
        cmd(apss_pkg::PD_STBY, apss_pkg::KIND_CONV); pst("f2", apss_pkg::PST_CONV, SPU + AB);
        cmd(0, apss_pkg::KIND_PD); pst("fast_stby", apss_pkg::PST_STBY, AB);
        cmd(apss_pkg::PD_SLEEP, apss_pkg::KIND_CAL); st("cal_on", 5'h12, 0);
        cmd(0, apss_pkg::KIND_PD); pst("cal_sleep", apss_pkg::PST_SLEEP, AB);
        cmd(apss_pkg::PD_STBY, apss_pkg::KIND_CAL); st("cal_idle", 5'h01, 60);
        cmd(0, apss_pkg::KIND_PD); pst("stby2", apss_pkg::PST_STBY, SBY);
        cmd(0, apss_pkg::KIND_CAL); st("cal_end", 5'h02, 3020);
        d0 = dflt_n;
        cmd(apss_pkg::PD_RESET, apss_pkg::KIND_PD); st("swrst_mid", 5'h0f, 10);
        st("swrst", 5'h02, SWR + 10); wb(0, apss_pkg::OFS_CTRL, 0); chk("ctl_dflt", 0, q);
        chk("dflt_swrst", 1, dflt_n - d0);
        cmd(apss_pkg::PD_RESET, apss_pkg::KIND_CAL); cmd(0, apss_pkg::KIND_PD);
        st("swrst_cal", 5'h02, RAB + 20); wb(0, apss_pkg::OFS_CTRL, 0); chk("ctl_c", 0, q);
        cmd(apss_pkg::PD_RESET, apss_pkg::KIND_CONV); pst("c3", apss_pkg::PST_CONV, BPU + AB);
        cmd(0, apss_pkg::KIND_PD); st("swrst_conv", 5'h02, RAB + 20);
        wb(0, apss_pkg::OFS_CTRL, 0); chk("ctl_v", 0, q);
        cmd(0, apss_pkg::KIND_CONV); pst("c4", apss_pkg::PST_CONV, BPU + AB);
        d0 = dflt_n;
        hw_n <= 0; repeat (10) @(posedge core_clk); hw_n <= 1;
        pst("hw_reset", apss_pkg::PST_STBY, HWR);
        chk("dflt_hw", 1, dflt_n - d0);
        d0 = dflt_n;
        por <= 0; repeat (10) @(posedge core_clk); por <= 1;
        pst("por2", apss_pkg::PST_STBY, PRC);
        chk("dflt_por", 1, dflt_n - d0);
        results();
    end
endmodule : tb_top
